// ---- pmcfg_top.sv ----
`default_nettype none
module pmcfg_top #(
    parameter int unsigned BLANK_CYC = pmcfg_pkg::BLANK_CYC,
    parameter int unsigned PG_CYC_0 = pmcfg_pkg::PG_CYC_0,
    parameter int unsigned PG_CYC_1 = pmcfg_pkg::PG_CYC_1,
    parameter int unsigned PG_CYC_2 = pmcfg_pkg::PG_CYC_2,
    parameter int unsigned PG_CYC_3 = pmcfg_pkg::PG_CYC_3,
    parameter int unsigned BUTTON_SHORT_CYC = pmcfg_pkg::BUTTON_SHORT_CYC,
    parameter int unsigned BUTTON_LONG_CYC = pmcfg_pkg::BUTTON_LONG_CYC,
    parameter int unsigned SLEW_BASE_CYC = pmcfg_pkg::SLEW_BASE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register access from the serial engine
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic write_unlocked_in,
    output logic [7:0] reg_rdata_out,
    output logic write_rejected_out,
    // Sequencer, trigger and strap
    input wire logic seq_update_in,
    input wire logic seq_switch_a_in,
    input wire logic seq_linear_in,
    input wire logic go_set_in,
    input wire logic trigger_bypass_in,
    input wire logic [2:0] slew_code_in,
    input wire logic strap_valid_in,
    input wire logic [5:0] resistor_select_strap_in,
    output logic go_busy_out,
    // Supervisor
    input wire logic rails_ok_in,
    input wire logic button_active_in,
    input wire logic power_fail_out_n_in,
    output logic power_good_out,
    output logic button_reset_out,
    output logic [2:0] monitor_blank_out,
    // General pins
    input wire logic general_pin_one_in,
    input wire logic general_pin_three_in,
    output logic general_pin_one_out,
    output logic general_pin_one_oe_out,
    output logic general_output_two_out,
    output logic general_output_two_oe_out,
    output logic general_pin_three_out,
    output logic general_pin_three_oe_out,
    output logic warm_reset_n_out,
    // Power path
    output logic [2:0] switch_enable_out,
    output logic [2:0] switch_discharge_out,
    output logic linear_reg_enable_out,
    output pmcfg_pkg::pmcfg_cfg_t cfg_out,
    output pmcfg_pkg::pmcfg_volt_t volt_out
);
    if (BLANK_CYC < 1 || PG_CYC_0 < 1 || PG_CYC_1 < 1 || PG_CYC_2 < 1 || PG_CYC_3 < 1 ||
        BUTTON_SHORT_CYC < 1 || BUTTON_LONG_CYC < 1 || SLEW_BASE_CYC < 128) begin : g_bad_param
        $error("pmcfg_top: a cycle count is too small");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
        if (cur < tgt) begin
            return cur + 6'h01;
        end else if (cur > tgt) begin
            return cur - 6'h01;
        end
        return cur;
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] mask);
        return (old & ~mask) | (wr & mask);
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] enable_q;
    logic [7:0] cfg_one_q;
    logic [7:0] cfg_two_q;
    logic [7:0] cfg_three_q;
    logic [7:0] buck_a_q;
    logic [7:0] buck_b_q;
    logic [7:0] buck_c_q;
    logic strap_done_q;
    logic [7:0] rdata_q;
    logic reject_q;

    wire logic wr_ok = reg_wr_in & write_unlocked_in;
    wire logic wr_enable = wr_ok && reg_addr_in == pmcfg_pkg::REG_ENABLE;
    wire logic wr_cfg_one = wr_ok && reg_addr_in == pmcfg_pkg::REG_CFG_ONE;
    wire logic wr_cfg_two = wr_ok && reg_addr_in == pmcfg_pkg::REG_CFG_TWO;
    wire logic wr_cfg_three = wr_ok && reg_addr_in == pmcfg_pkg::REG_CFG_THREE;
    wire logic wr_buck_a = wr_ok && reg_addr_in == pmcfg_pkg::REG_BUCK_A;
    wire logic wr_buck_b = wr_ok && reg_addr_in == pmcfg_pkg::REG_BUCK_B;
    wire logic wr_buck_c = wr_ok && reg_addr_in == pmcfg_pkg::REG_BUCK_C;
    wire logic addr_mapped = reg_addr_in >= pmcfg_pkg::REG_ENABLE && reg_addr_in <= pmcfg_pkg::REG_BUCK_C;

    logic [7:0] enable_d;
    always_comb begin
        enable_d = wr_enable ? merge(enable_q, reg_wdata_in, pmcfg_pkg::MASK_ENABLE) : enable_q;
        if (seq_update_in) begin
            enable_d[pmcfg_pkg::EN_SWITCH_A] = seq_switch_a_in;
            enable_d[pmcfg_pkg::EN_LINEAR] = seq_linear_in;
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_in)
            pmcfg_pkg::REG_ENABLE: rd_mux = enable_q;
            pmcfg_pkg::REG_CFG_ONE: rd_mux = cfg_one_q;
            pmcfg_pkg::REG_CFG_TWO: rd_mux = cfg_two_q;
            pmcfg_pkg::REG_CFG_THREE: rd_mux = cfg_three_q;
            pmcfg_pkg::REG_BUCK_A: rd_mux = buck_a_q;
            pmcfg_pkg::REG_BUCK_B: rd_mux = buck_b_q;
            pmcfg_pkg::REG_BUCK_C: rd_mux = buck_c_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            enable_q <= pmcfg_pkg::RST_ENABLE;
            cfg_one_q <= pmcfg_pkg::RST_CFG_ONE;
            cfg_two_q <= pmcfg_pkg::RST_CFG_TWO;
            cfg_three_q <= pmcfg_pkg::RST_CFG_THREE;
            buck_a_q <= pmcfg_pkg::RST_BUCK_AB;
            buck_b_q <= pmcfg_pkg::RST_BUCK_AB;
            buck_c_q <= pmcfg_pkg::RST_BUCK_C;
            strap_done_q <= 1'b0;
            rdata_q <= 8'h00;
            reject_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            if (wr_cfg_one) begin
                cfg_one_q <= merge(cfg_one_q, reg_wdata_in, pmcfg_pkg::MASK_CFG_ONE);
            end
            if (wr_cfg_two) begin
                cfg_two_q <= merge(cfg_two_q, reg_wdata_in, pmcfg_pkg::MASK_CFG_TWO);
            end
            if (wr_cfg_three) begin
                cfg_three_q <= merge(cfg_three_q, reg_wdata_in, pmcfg_pkg::MASK_CFG_THREE);
            end
            if (wr_buck_a) begin
                buck_a_q <= merge(buck_a_q, reg_wdata_in, pmcfg_pkg::MASK_BUCK);
            end
            if (wr_buck_b) begin
                buck_b_q <= merge(buck_b_q, reg_wdata_in, pmcfg_pkg::MASK_BUCK);
            end
            strap_done_q <= 1'b1;
            if (wr_buck_c) begin
                buck_c_q <= merge(buck_c_q, reg_wdata_in, pmcfg_pkg::MASK_BUCK);
            end else if (!strap_done_q && strap_valid_in) begin
                buck_c_q[5:0] <= resistor_select_strap_in;
            end
            rdata_q <= reg_rd_in ? rd_mux : rdata_q;
            reject_q <= reg_wr_in & ~write_unlocked_in & addr_mapped;
        end
    end

    // ****************************************
    // Voltage ramp for bucks A and B
    // ****************************************
    pmcfg_pkg::pmcfg_ramp_t ramp_q;
    logic go_q;
    logic [5:0] act_a_q;
    logic [5:0] act_b_q;
    logic [31:0] step_cnt_q;

    wire logic [5:0] tgt_a = buck_a_q[5:0];
    wire logic [5:0] tgt_b = buck_b_q[5:0];
    wire logic at_target = act_a_q == tgt_a && act_b_q == tgt_b;
    wire logic ramp_req = go_q | (trigger_bypass_in & ~at_target);
    wire logic [31:0] step_len = (slew_code_in == pmcfg_pkg::SLEW_IMMEDIATE) ? 32'd1 :
                                 32'(SLEW_BASE_CYC >> slew_code_in);
    wire logic ramp_done = ramp_q == pmcfg_pkg::RAMP_STEP && at_target;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ramp_q <= pmcfg_pkg::RAMP_IDLE;
            go_q <= 1'b0;
            act_a_q <= pmcfg_pkg::RST_BUCK_AB[5:0];
            act_b_q <= pmcfg_pkg::RST_BUCK_AB[5:0];
            step_cnt_q <= 32'd0;
        end else begin
            if (go_set_in) begin
                go_q <= 1'b1;
            end else if (ramp_done) begin
                go_q <= 1'b0;
            end
            case (ramp_q)
                pmcfg_pkg::RAMP_IDLE: begin
                    if (ramp_req) begin
                        step_cnt_q <= step_len - 32'd1;
                        ramp_q <= pmcfg_pkg::RAMP_WAIT;
                    end
                end
                pmcfg_pkg::RAMP_WAIT: begin
                    if (step_cnt_q == 32'd0) begin
                        act_a_q <= step_toward(act_a_q, tgt_a);
                        act_b_q <= step_toward(act_b_q, tgt_b);
                        ramp_q <= pmcfg_pkg::RAMP_STEP;
                    end else begin
                        step_cnt_q <= step_cnt_q - 32'd1;
                    end
                end
                pmcfg_pkg::RAMP_STEP: begin
                    if (at_target) begin
                        ramp_q <= pmcfg_pkg::RAMP_IDLE;
                    end else begin
                        step_cnt_q <= step_len - 32'd1;
                        ramp_q <= pmcfg_pkg::RAMP_WAIT;
                    end
                end
                default: ramp_q <= pmcfg_pkg::RAMP_IDLE;
            endcase
        end
    end

    // ****************************************
    // Monitor blanking, power good, button
    // ****************************************
    logic [31:0] blank_cnt_q [3];
    logic [2:0] blank_q;
    wire logic [2:0] buck_wr = {wr_buck_c, wr_buck_b, wr_buck_a};

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 3; i++) begin
            if (sys_rst_in) begin
                blank_cnt_q[i] <= 32'd0;
                blank_q[i] <= 1'b0;
            end else if (buck_wr[i]) begin
                blank_cnt_q[i] <= 32'(BLANK_CYC) - 32'd1;
                blank_q[i] <= 1'b1;
            end else if (blank_cnt_q[i] != 32'd0) begin
                blank_cnt_q[i] <= blank_cnt_q[i] - 32'd1;
            end else begin
                blank_q[i] <= 1'b0;
            end
        end
    end

    logic [31:0] pg_cnt_q;
    logic pg_q;
    logic [31:0] pg_len;
    always_comb begin
        case (cfg_one_q[pmcfg_pkg::C1_PG_DELAY +: 2])
            2'h0: pg_len = 32'(PG_CYC_0);
            2'h1: pg_len = 32'(PG_CYC_1);
            2'h2: pg_len = 32'(PG_CYC_2);
            default: pg_len = 32'(PG_CYC_3);
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !rails_ok_in) begin
            pg_cnt_q <= 32'd0;
            pg_q <= 1'b0;
        end else if (pg_cnt_q + 32'd1 >= pg_len) begin
            pg_q <= 1'b1;
        end else begin
            pg_cnt_q <= pg_cnt_q + 32'd1;
        end
    end

    logic [31:0] btn_cnt_q;
    logic btn_fired_q;
    logic btn_pulse_q;
    wire logic [31:0] btn_len = cfg_one_q[pmcfg_pkg::C1_BUTTON_TIME] ? 32'(BUTTON_LONG_CYC) :
                                32'(BUTTON_SHORT_CYC);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !button_active_in) begin
            btn_cnt_q <= 32'd0;
            btn_fired_q <= 1'b0;
            btn_pulse_q <= 1'b0;
        end else begin
            btn_pulse_q <= 1'b0;
            if (!btn_fired_q) begin
                if (btn_cnt_q + 32'd1 >= btn_len) begin
                    btn_fired_q <= 1'b1;
                    btn_pulse_q <= 1'b1;
                end else begin
                    btn_cnt_q <= btn_cnt_q + 32'd1;
                end
            end
        end
    end

    // ****************************************
    // Pins and power path
    // ****************************************
    wire logic pin_one_sel = cfg_one_q[pmcfg_pkg::C1_PIN_ONE_SEL];
    wire logic warm_sel = cfg_two_q[pmcfg_pkg::C2_WARM_RESET];
    wire logic two_push_pull = cfg_one_q[pmcfg_pkg::C1_OUT_TWO_BUF];
    wire logic two_level = pin_one_sel ? general_pin_one_in : enable_q[pmcfg_pkg::EN_OUT_TWO];
    wire logic pin_one_oe_d = ~pin_one_sel & ~enable_q[pmcfg_pkg::EN_PIN_ONE];
    wire logic two_oe_d = ~two_level | two_push_pull;
    wire logic pin_three_oe_d = ~warm_sel & ~enable_q[pmcfg_pkg::EN_PIN_THREE];
    wire logic [2:0] pfail_off = cfg_three_q[pmcfg_pkg::C3_PFAIL_OFF +: 3] & {3{~power_fail_out_n_in}};
    wire logic [2:0] switch_on_d = enable_q[3:1] & ~pfail_off;
    wire logic [2:0] discharge_d = cfg_three_q[pmcfg_pkg::C3_DISCHARGE +: 3] & ~switch_on_d;

    logic pin_one_oe_q;
    logic two_q;
    logic two_oe_q;
    logic pin_three_oe_q;
    logic warm_n_q;
    logic [2:0] switch_on_q;
    logic [2:0] discharge_q;
    logic linear_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_one_oe_q <= 1'b0;
            two_q <= 1'b0;
            two_oe_q <= 1'b0;
            pin_three_oe_q <= 1'b0;
            warm_n_q <= 1'b1;
            switch_on_q <= 3'h0;
            discharge_q <= 3'h0;
            linear_q <= 1'b0;
        end else begin
            pin_one_oe_q <= pin_one_oe_d;
            two_q <= two_level;
            two_oe_q <= two_oe_d;
            pin_three_oe_q <= pin_three_oe_d;
            warm_n_q <= ~warm_sel | general_pin_three_in;
            switch_on_q <= switch_on_d;
            discharge_q <= discharge_d;
            linear_q <= enable_q[pmcfg_pkg::EN_LINEAR];
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_out = rdata_q;
    assign write_rejected_out = reject_q;
    assign go_busy_out = go_q;
    assign power_good_out = pg_q;
    assign button_reset_out = btn_pulse_q;
    assign monitor_blank_out = blank_q;
    assign general_pin_one_out = 1'b0;
    assign general_pin_one_oe_out = pin_one_oe_q;
    assign general_output_two_out = two_q;
    assign general_output_two_oe_out = two_oe_q;
    assign general_pin_three_out = 1'b0;
    assign general_pin_three_oe_out = pin_three_oe_q;
    assign warm_reset_n_out = warm_n_q;
    assign switch_enable_out = switch_on_q;
    assign switch_discharge_out = discharge_q;
    assign linear_reg_enable_out = linear_q;
    assign cfg_out.button_long = cfg_one_q[pmcfg_pkg::C1_BUTTON_TIME];
    assign cfg_out.pg_delay = cfg_one_q[pmcfg_pkg::C1_PG_DELAY +: 2];
    assign cfg_out.tight_supervision = cfg_one_q[pmcfg_pkg::C1_TIGHT];
    assign cfg_out.lockout_level = cfg_one_q[pmcfg_pkg::C1_LOCKOUT +: 2];
    assign cfg_out.lockout_hysteresis = cfg_two_q[pmcfg_pkg::C2_HYST];
    assign cfg_out.switch_c_current_limit = cfg_two_q[pmcfg_pkg::C2_ILIM_C +: 2];
    assign cfg_out.switch_b_current_limit = cfg_two_q[pmcfg_pkg::C2_ILIM_B +: 2];
    assign cfg_out.buck_pfm = {buck_c_q[pmcfg_pkg::BUCK_PFM], buck_b_q[pmcfg_pkg::BUCK_PFM],
                               buck_a_q[pmcfg_pkg::BUCK_PFM]};
    assign volt_out.buck_a = act_a_q;
    assign volt_out.buck_b = act_b_q;
    assign volt_out.buck_c = buck_c_q[5:0];
endmodule
`default_nettype wire

// ---- pmcfg_pkg.sv ----
`default_nettype none
package pmcfg_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_ENABLE = 8'h12;
    localparam logic [7:0] REG_CFG_ONE = 8'h13;
    localparam logic [7:0] REG_CFG_TWO = 8'h14;
    localparam logic [7:0] REG_CFG_THREE = 8'h15;
    localparam logic [7:0] REG_BUCK_A = 8'h16;
    localparam logic [7:0] REG_BUCK_B = 8'h17;
    localparam logic [7:0] REG_BUCK_C = 8'h18;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_CFG_ONE = 8'h08;
    localparam logic [7:0] RST_CFG_TWO = 8'h40;
    localparam logic [7:0] RST_CFG_THREE = 8'h00;
    localparam logic [7:0] RST_BUCK_AB = 8'hB5;
    localparam logic [7:0] RST_BUCK_C = 8'h98;
    localparam logic [7:0] MASK_ENABLE = 8'h7F;
    localparam logic [7:0] MASK_CFG_ONE = 8'hFF;
    localparam logic [7:0] MASK_CFG_TWO = 8'hCF;
    localparam logic [7:0] MASK_CFG_THREE = 8'h3F;
    localparam logic [7:0] MASK_BUCK = 8'hBF;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int EN_PIN_THREE = 6;
    localparam int EN_OUT_TWO = 5;
    localparam int EN_PIN_ONE = 4;
    localparam int EN_SWITCH_A = 1;
    localparam int EN_LINEAR = 0;
    localparam int C1_BUTTON_TIME = 7;
    localparam int C1_OUT_TWO_BUF = 6;
    localparam int C1_PIN_ONE_SEL = 5;
    localparam int C1_PG_DELAY = 3;
    localparam int C1_TIGHT = 2;
    localparam int C1_LOCKOUT = 0;
    localparam int C2_WARM_RESET = 7;
    localparam int C2_HYST = 6;
    localparam int C2_ILIM_C = 2;
    localparam int C2_ILIM_B = 0;
    localparam int C3_PFAIL_OFF = 3;
    localparam int C3_DISCHARGE = 0;
    localparam int BUCK_PFM = 7;
    // ****************************************
    // Timing
    // ****************************************
    localparam longint unsigned CLK_PERIOD_NS = 100;
    localparam longint unsigned BLANK_MS = 5;
    localparam longint unsigned PG_MS_0 = 10;
    localparam longint unsigned PG_MS_1 = 20;
    localparam longint unsigned PG_MS_2 = 50;
    localparam longint unsigned PG_MS_3 = 150;
    localparam longint unsigned BUTTON_SHORT_S = 8;
    localparam longint unsigned BUTTON_LONG_S = 15;
    localparam longint unsigned SLEW_BASE_NS = 160000;
    localparam int unsigned BLANK_CYC = int'(BLANK_MS * 1000000 / CLK_PERIOD_NS);
    localparam int unsigned PG_CYC_0 = int'(PG_MS_0 * 1000000 / CLK_PERIOD_NS);
    localparam int unsigned PG_CYC_1 = int'(PG_MS_1 * 1000000 / CLK_PERIOD_NS);
    localparam int unsigned PG_CYC_2 = int'(PG_MS_2 * 1000000 / CLK_PERIOD_NS);
    localparam int unsigned PG_CYC_3 = int'(PG_MS_3 * 1000000 / CLK_PERIOD_NS);
    localparam int unsigned BUTTON_SHORT_CYC = int'(BUTTON_SHORT_S * 1000000000 / CLK_PERIOD_NS);
    localparam int unsigned BUTTON_LONG_CYC = int'(BUTTON_LONG_S * 1000000000 / CLK_PERIOD_NS);
    localparam int unsigned SLEW_BASE_CYC = int'(SLEW_BASE_NS / CLK_PERIOD_NS);
    localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic button_long;
        logic [1:0] pg_delay;
        logic tight_supervision;
        logic [1:0] lockout_level;
        logic lockout_hysteresis;
        logic [1:0] switch_c_current_limit;
        logic [1:0] switch_b_current_limit;
        logic [2:0] buck_pfm;
    } pmcfg_cfg_t;
    typedef struct packed {
        logic [5:0] buck_a;
        logic [5:0] buck_b;
        logic [5:0] buck_c;
    } pmcfg_volt_t;
    typedef enum logic [1:0] {
        RAMP_IDLE,
        RAMP_WAIT,
        RAMP_STEP
    } pmcfg_ramp_t;
endpackage
`default_nettype wire

// ---- pmcfg_checker.sv ----
`default_nettype none
module pmcfg_checker (
    // Clock, reset and stimulus
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic write_unlocked_in,
    input wire logic go_set_in,
    input wire logic trigger_bypass_in,
    input wire logic rails_ok_in,
    // Design outputs
    input wire logic write_rejected_out,
    input wire logic go_busy_out,
    input wire logic power_good_out,
    input wire logic [2:0] monitor_blank_out,
    input wire logic general_pin_one_out,
    input wire logic general_pin_three_out,
    input wire logic [2:0] switch_enable_out,
    input wire logic [2:0] switch_discharge_out,
    input wire pmcfg_pkg::pmcfg_volt_t volt_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    wire logic mapped = reg_addr_in >= 8'h12 && reg_addr_in <= 8'h18;
    lock_reject_a: assert property (reg_wr_in && !write_unlocked_in && mapped |=> write_rejected_out)
        else $error("locked write not flagged");
    unlock_pass_a: assert property (reg_wr_in && write_unlocked_in |=> !write_rejected_out)
        else $error("unlocked write flagged");
    blank_start_a: assert property (reg_wr_in && write_unlocked_in && reg_addr_in == 8'h16 |=> monitor_blank_out[0] [*8])
        else $error("buck a write did not blank");
    pg_hold_a: assert property ($rose(rails_ok_in) |=> !power_good_out [*8])
        else $error("power good rose early");
    pg_drop_a: assert property ($fell(rails_ok_in) |=> !power_good_out)
        else $error("power good late on fall");
    open_drain_a: assert property (!general_pin_one_out && !general_pin_three_out)
        else $error("open drain pin driven high");
    discharge_off_a: assert property ((switch_discharge_out & switch_enable_out) == 3'h0)
        else $error("discharge while switch on");
    go_busy_a: assert property (go_set_in |=> go_busy_out)
        else $error("trigger not busy");
    hold_code_a: assert property (!trigger_bypass_in && !go_busy_out && !go_set_in |=> $stable(volt_out.buck_a))
        else $error("code applied without trigger");
    reset_code_a: assert property ($fell(sys_rst_in) |-> volt_out.buck_a == 6'h35 && volt_out.buck_b == 6'h35)
        else $error("applied code reset wrong");
endmodule
`default_nettype wire

// ---- pmcfg_host.sv ----
`default_nettype none
module pmcfg_host (
    // Clock and read data
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // Register strobes
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic unlocked_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {wr_out, rd_out, addr_out, wdata_out, unlocked_out} = '0;
    task automatic access(input logic wr, input logic [7:0] a, d, input logic unl, output logic [7:0] q);
        @(posedge clk_in);
        #1;
        wr_out = wr;
        rd_out = !wr;
        addr_out = a;
        wdata_out = d;
        unlocked_out = unl;
        @(posedge clk_in);
        #1;
        q = rdata_in;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        unlocked_out = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb_pmic_config_register_bank.sv ----
`default_nettype none
module tb_pmic_config_register_bank;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PG [4] = '{10, 20, 30, 40};
    localparam logic [7:0] RV [7] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'hB5, 8'hB5, 8'h98};
    localparam logic [7:0] MK [7] = '{8'h7F, 8'hFF, 8'hCF, 8'h3F, 8'hBF, 8'hBF, 8'hBF};
    localparam int BLANK = 20, BTN_S = 50, BTN_L = 80, SLEW = 128;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr, rd, unl, seq_up, go_set, bypass, rails, pfo_n, pin1, rej, busy, pg, lin, oe1, oe2, oe3;
    logic seq_v, btn, pin3, brst, out2, wrst;
    logic [7:0] addr, wdata, rdata, q;
    logic [2:0] sw_en, sw_dis, blank;
    pmcfg_pkg::pmcfg_volt_t volt;
    pmcfg_pkg::pmcfg_cfg_t cfg;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    always #50 clk_in = ~clk_in;
    pmcfg_host host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wdata), .unlocked_out(unl));
    pmcfg_top #(.BLANK_CYC(BLANK), .PG_CYC_0(PG[0]), .PG_CYC_1(PG[1]), .PG_CYC_2(PG[2]), .PG_CYC_3(PG[3]),
        .BUTTON_SHORT_CYC(BTN_S), .BUTTON_LONG_CYC(BTN_L), .SLEW_BASE_CYC(SLEW)) uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .write_unlocked_in(unl), .reg_rdata_out(rdata), .write_rejected_out(rej),
        .seq_update_in(seq_up), .seq_switch_a_in(seq_v), .seq_linear_in(seq_v), .go_set_in(go_set),
        .trigger_bypass_in(bypass), .slew_code_in(3'h7), .strap_valid_in(1'b0), .resistor_select_strap_in(6'h00),
        .go_busy_out(busy), .rails_ok_in(rails), .button_active_in(btn), .power_fail_out_n_in(pfo_n),
        .power_good_out(pg), .button_reset_out(brst), .monitor_blank_out(blank), .general_pin_one_in(pin1),
        .general_pin_three_in(pin3), .general_pin_one_out(), .general_pin_one_oe_out(oe1),
        .general_output_two_out(out2), .general_output_two_oe_out(oe2), .general_pin_three_out(),
        .general_pin_three_oe_out(oe3), .warm_reset_n_out(wrst), .switch_enable_out(sw_en),
        .switch_discharge_out(sw_dis), .linear_reg_enable_out(lin), .cfg_out(cfg), .volt_out(volt));
    task automatic check(input string name, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic w(input logic [7:0] a, d);
        host.access(1'b1, a, d, 1'b1, q);
    endtask
    task automatic r(input logic [7:0] a, exp);
        host.access(1'b0, a, 8'h00, 1'b1, q);
        check("read", q, exp);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask
    // Counts cycles while the selected condition holds
    task automatic span(input int sel, output int c);
        c = 0;
        while (sel == 0 ? blank[0] : sel == 1 ? !pg : sel == 2 ? busy : sel == 3 ? volt.buck_b != 6'h30 : !brst) begin
            tick(1);
            c++;
            if (c > 300) begin
                n_mismatch++;
                wrap_up();
            end
        end
    endtask
    initial begin
        {seq_up, go_set, bypass, rails, pin1, seq_v, btn, pin3} = '0;
        pfo_n = 1'b1;
        tick(16);
        sys_rst_in = 1'b0;
        for (int i = 0; i < 7; i++) r(8'h12 + i, RV[i]);
        check("cfg low", cfg[7:0], 8'h87);
        check("cfg high", {2'h0, cfg[13:8]}, 8'h08);
        for (int i = 0; i < 7; i++) begin
            w(8'h12 + i, 8'hFF);
            r(8'h12 + i, MK[i]);
        end
        tick(2);
        check("enables", {4'h0, sw_en, lin}, 8'h0F);
        check("cfg all", cfg[13:6], 8'hFF);
        check("discharge", {5'h0, sw_dis}, 8'h00);
        check("applied", {2'b0, volt.buck_a}, 8'h35);
        host.access(1'b1, 8'h13, 8'h00, 1'b0, q);
        check("reject", {7'h0, rej}, 8'h01);
        r(8'h13, 8'hFF);
        r(8'h1F, 8'h00);
        pfo_n = 1'b0;
        tick(3);
        check("pfail", {2'b0, sw_en, sw_dis}, 8'h07);
        pfo_n = 1'b1;
        seq_up = 1'b1;
        tick(2);
        r(8'h12, 8'h7C);
        seq_v = 1'b1;
        tick(2);
        r(8'h12, 8'h7F);
        seq_up = 1'b0;
        w(8'h12, 8'h00);
        tick(2);
        check("pins selected", {4'h0, oe1, oe3, wrst, out2}, 8'h00);
        pin1 = 1'b1;
        tick(3);
        check("out two follows", {6'h0, out2, oe2}, 8'h03);
        w(8'h13, 8'h08);
        w(8'h14, 8'h40);
        tick(2);
        check("pins driven", {4'h0, oe1, oe2, oe3, wrst}, 8'h0F);
        w(8'h16, 8'hB6);
        span(0, n);
        check("blank", 8'(n >= 19 && n <= 21), 8'h01);
        go_set = 1'b1;
        tick(1);
        go_set = 1'b0;
        span(2, n);
        check("ramp", {2'b0, volt.buck_a}, 8'h36);
        bypass = 1'b1;
        w(8'h17, 8'hB0);
        span(3, n);
        tick(3);
        bypass = 1'b0;
        check("bypass", {2'b0, volt.buck_b}, 8'h30);
        for (int c = 0; c < 4; c++) begin
            w(8'h13, 8'(c << 3));
            rails = 1'b1;
            span(1, n);
            check("pg delay", 8'(n >= PG[c] - 1 && n <= PG[c] + 1), 8'h01);
            rails = 1'b0;
            tick(2);
            check("pg fall", {7'h0, pg}, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            w(8'h13, 8'(k << 7));
            btn = 1'b1;
            span(4, n);
            btn = 1'b0;
            check("button", 8'((n - (k ? BTN_L : BTN_S)) inside {-1, 0, 1}), 8'h01);
        end
        wrap_up();
    end
endmodule
bind pmcfg_top pmcfg_checker chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .write_unlocked_in(write_unlocked_in), .go_set_in(go_set_in),
    .trigger_bypass_in(trigger_bypass_in), .rails_ok_in(rails_ok_in), .write_rejected_out(write_rejected_out),
    .go_busy_out(go_busy_out), .power_good_out(power_good_out), .monitor_blank_out(monitor_blank_out),
    .general_pin_one_out(general_pin_one_out), .general_pin_three_out(general_pin_three_out),
    .switch_enable_out(switch_enable_out), .switch_discharge_out(switch_discharge_out), .volt_out(volt_out));
`default_nettype wire
